// ---- design/csfb_map.vh ----
`ifndef CSFB_MAP_VH
`define CSFB_MAP_VH

// Flag positions in the core flags / reset cause register
`define CSFB_FLAG_CARRY       0
`define CSFB_FLAG_NIBBLE      1
`define CSFB_FLAG_ZERO        2
`define CSFB_FLAG_SLEEP       3
`define CSFB_FLAG_WDOG        4

// Reset value and read mask of the flags register
`define CSFB_STATUS_RST       8'h18
`define CSFB_STATUS_RD_MASK   8'h1f

// Core register window at the bottom of every served bank
`define CSFB_CORE_LAST        7'h0b
`define CSFB_CORE_STATUS_IDX  4'h3

// Common region at the top of every served bank
`define CSFB_COMMON_BASE      7'h70

// Banks served by this map
`define CSFB_BANK_FIRST       5'h08
`define CSFB_BANK_LAST        5'h17

// Operation kinds from the instruction decoder
`define CSFB_OP_NONE          3'h0
`define CSFB_OP_ADD           3'h1
`define CSFB_OP_SUB           3'h2
`define CSFB_OP_LOGIC         3'h3
`define CSFB_OP_ROT_RIGHT     3'h4
`define CSFB_OP_ROT_LEFT      3'h5
`define CSFB_OP_CLEAR         3'h6

`endif

// ---- design/csfb_alu_flags.v ----
`timescale 1ns/1ps
`include "csfb_map.vh"

module csfb_alu_flags (
  input  wire [2:0] i_op_kind,
  input  wire [7:0] i_op_a,
  input  wire [7:0] i_op_b,
  input  wire       i_carry_in,
  output reg  [7:0] o_result,
  output reg  [2:0] o_flags,
  output reg  [2:0] o_flag_mask
);

  reg [8:0] sum9;
  reg [4:0] sum5;

  // Result and flags for each kind of operation
  always @* begin
    sum9        = 9'h000;
    sum5        = 5'h00;
    o_result    = i_op_a;
    o_flags     = 3'h0;
    o_flag_mask = 3'h0;
    case (i_op_kind)
      `CSFB_OP_ADD: begin
        sum9        = {1'b0, i_op_a} + {1'b0, i_op_b};
        sum5        = {1'b0, i_op_a[3:0]} + {1'b0, i_op_b[3:0]};
        o_result    = sum9[7:0];
        o_flag_mask = 3'h7;
      end
      `CSFB_OP_SUB: begin
        // Add two's complement, carries read as inverted borrows
        sum9        = {1'b0, i_op_a} + {1'b0, ~i_op_b} + 9'h001; // RULE11
        sum5        = {1'b0, i_op_a[3:0]} + {1'b0, ~i_op_b[3:0]} + 5'h01; // RULE11
        o_result    = sum9[7:0];
        o_flag_mask = 3'h7;
      end
      `CSFB_OP_LOGIC: begin
        o_result    = i_op_a;
        o_flag_mask = 3'h4;
      end
      `CSFB_OP_ROT_RIGHT: begin
        o_result    = {i_carry_in, i_op_a[7:1]};
        o_flag_mask = 3'h1;
      end
      `CSFB_OP_ROT_LEFT: begin
        o_result    = {i_op_a[6:0], i_carry_in};
        o_flag_mask = 3'h1;
      end
      `CSFB_OP_CLEAR: begin
        o_result    = 8'h00;
        o_flag_mask = 3'h4;
      end
      default: begin
        o_result    = i_op_a;
        o_flag_mask = 3'h0;
      end
    endcase
    o_flags[`CSFB_FLAG_ZERO]   = (o_result == 8'h00); // RULE8
    o_flags[`CSFB_FLAG_NIBBLE] = sum5[4]; // RULE9
    if (i_op_kind == `CSFB_OP_ROT_RIGHT)
      o_flags[`CSFB_FLAG_CARRY] = i_op_a[0]; // RULE12
    else if (i_op_kind == `CSFB_OP_ROT_LEFT)
      o_flags[`CSFB_FLAG_CARRY] = i_op_a[7]; // RULE12
    else
      o_flags[`CSFB_FLAG_CARRY] = sum9[8]; // RULE10
  end

endmodule // csfb_alu_flags

// ---- design/csfb_bank_decode.v ----
`timescale 1ns/1ps
`include "csfb_map.vh"

module csfb_bank_decode (
  input  wire [4:0]  i_bank_sel,
  input  wire [6:0]  i_offset,
  output wire        o_in_range,
  output wire        o_core_hit,
  output wire [3:0]  o_core_idx,
  output wire        o_common_hit,
  output wire [3:0]  o_common_idx,
  output wire        o_unimpl_hit,
  output wire [11:0] o_data_addr
);

  // Bank times 80h plus in-bank offset
  assign o_data_addr  = {i_bank_sel, i_offset}; // RULE16

  // Banks 8 to 23 only
  assign o_in_range   = (i_bank_sel >= `CSFB_BANK_FIRST) && (i_bank_sel <= `CSFB_BANK_LAST);

  // Region split inside a bank
  assign o_core_hit   = o_in_range && (i_offset <= `CSFB_CORE_LAST); // RULE13
  assign o_core_idx   = i_offset[3:0];
  assign o_common_hit = o_in_range && (i_offset >= `CSFB_COMMON_BASE); // RULE15
  assign o_common_idx = i_offset[3:0];
  assign o_unimpl_hit = o_in_range && !o_core_hit && !o_common_hit; // RULE14

endmodule // csfb_bank_decode

// ---- design/csfb_core_status.v ----
`timescale 1ns/1ps
`include "csfb_map.vh"
// Behaviour
// RULE1: Flags register is a normal destination for any instruction.
// RULE2: Flag-updating op into flags register drops written flags, loads computed ones.
// RULE3: Watchdog expiry and sleep entered flags ignore all writes.
// RULE4: Bits seven to five are unimplemented and read zero.
// RULE5: File clear on flags register zeros upper bits, sets zero flag.
// RULE6: Watchdog flag 1 on power-up, watchdog clear, sleep; 0 on timeout.
// RULE7: Sleep flag 1 on power-up or watchdog clear; 0 on sleep.
// RULE8: Zero flag set when result is zero, cleared otherwise.
// RULE9: Nibble carry is carry out of bit three on add/subtract.
// RULE10: Carry is carry out of the top bit on add/subtract.
// RULE11: Subtract adds two's complement, so carries are inverted borrows.
// RULE12: Rotates load carry with source low or high bit.
// RULE13: Offsets 00h to 0Bh of banks 8 to 23 reach core registers.
// RULE14: Unimplemented locations ignore writes and read zero.
// RULE15: Offsets 70h to 7Fh of every bank reach the common region; the code maps them only in banks 8 to 23.
// RULE16: Data address is bank times 80h plus seven-bit offset.

module csfb_core_status (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire [4:0]  i_bank_sel,
  input  wire [6:0]  i_offset,
  input  wire        i_rd_en,
  input  wire        i_wr_en,
  input  wire [7:0]  i_wr_data,
  input  wire [7:0]  i_core_rd_data,
  input  wire        i_op_valid,
  input  wire [2:0]  i_op_kind,
  input  wire [7:0]  i_op_a,
  input  wire [7:0]  i_op_b,
  input  wire        i_watchdog_clear_instr,
  input  wire        i_sleep_instr,
  input  wire        i_watchdog_timeout,
  output wire [7:0]  o_status,
  output wire [7:0]  o_alu_result,
  output wire        o_alu_valid,
  output wire [7:0]  o_rd_data,
  output wire        o_rd_valid,
  output wire [11:0] o_data_addr,
  output wire        o_core_wr_stb,
  output wire [3:0]  o_core_wr_idx,
  output wire [7:0]  o_core_wr_data,
  output wire        o_unmapped_access
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and flag computation

  wire        dec_in_range;
  wire        dec_core_hit;
  wire [3:0]  dec_core_idx;
  wire        dec_common_hit;
  wire [3:0]  dec_common_idx;
  wire        dec_unimpl_hit;
  wire [11:0] dec_data_addr;
  wire [7:0]  alu_result;
  wire [2:0]  alu_flags;
  wire [2:0]  alu_mask;

  reg  [7:0]  status_ff;
  reg  [7:0]  nxt_status;
  reg  [7:0]  common_mem [0:15];
  reg  [7:0]  rd_data_ff;
  reg  [7:0]  nxt_rd_data;
  reg         rd_valid_ff;
  reg  [7:0]  alu_result_ff;
  reg         alu_valid_ff;
  reg  [11:0] data_addr_ff;
  reg         core_wr_stb_ff;
  reg  [3:0]  core_wr_idx_ff;
  reg  [7:0]  core_wr_data_ff;
  reg         unmapped_ff;

  csfb_bank_decode u_decode (
    .i_bank_sel   (i_bank_sel),
    .i_offset     (i_offset),
    .o_in_range   (dec_in_range),
    .o_core_hit   (dec_core_hit),
    .o_core_idx   (dec_core_idx),
    .o_common_hit (dec_common_hit),
    .o_common_idx (dec_common_idx),
    .o_unimpl_hit (dec_unimpl_hit),
    .o_data_addr  (dec_data_addr)
  );

  csfb_alu_flags u_alu (
    .i_op_kind   (i_op_kind),
    .i_op_a      (i_op_a),
    .i_op_b      (i_op_b),
    .i_carry_in  (status_ff[`CSFB_FLAG_CARRY]),
    .o_result    (alu_result),
    .o_flags     (alu_flags),
    .o_flag_mask (alu_mask)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access qualifiers

  wire status_hit;
  wire status_wr;
  wire flag_op;
  wire flag_wr_block;

  // Flags register sits at core index 3 of every served bank
  assign status_hit    = dec_core_hit && (dec_core_idx == `CSFB_CORE_STATUS_IDX); // RULE1
  assign status_wr     = i_wr_en && status_hit; // RULE1
  assign flag_op       = i_op_valid && (alu_mask != 3'h0);
  // Any flag-updating op masks the written value of all three flags
  assign flag_wr_block = flag_op; // RULE2

  ////////////////////////////////////////////////////////////////////////////
  // Next value of the arithmetic flags, one slice per flag

  wire [2:0] nxt_flags;

  // Each slice picks the computed value, the written value or a hold
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_flag
      assign nxt_flags[g] = (i_op_valid && alu_mask[g]) ? alu_flags[g] : // RULE2
                            (status_wr && !flag_wr_block) ? i_wr_data[g] : // RULE1
                            status_ff[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next value of the reset cause flags

  reg        nxt_wdog;
  reg        nxt_sleep;

  // Core events only, register writes never reach these two bits
  always @* begin
    nxt_wdog  = status_ff[`CSFB_FLAG_WDOG];
    nxt_sleep = status_ff[`CSFB_FLAG_SLEEP];
    // Watchdog clear marks a clean run
    if (i_watchdog_clear_instr) begin
      nxt_wdog  = 1'b1; // RULE6
      nxt_sleep = 1'b1; // RULE7
    end
    // Sleep entry overrides clear for the sleep flag
    if (i_sleep_instr) begin
      nxt_wdog  = 1'b1; // RULE6
      nxt_sleep = 1'b0; // RULE7
    end
    // Timeout is the latest event and wins
    if (i_watchdog_timeout) begin
      nxt_wdog  = 1'b0; // RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next value of the whole flags register

  // Upper bits never hold a one
  always @* begin
    nxt_status                   = 8'h00; // RULE4 RULE5
    nxt_status[`CSFB_FLAG_WDOG]  = nxt_wdog; // RULE3
    nxt_status[`CSFB_FLAG_SLEEP] = nxt_sleep; // RULE3
    nxt_status[2:0]              = nxt_flags;
  end

  // Flags register, power-up value on reset
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      status_ff <= `CSFB_STATUS_RST; // RULE6 RULE7
    end else begin
      status_ff <= nxt_status; // RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Common region storage

  // Writes land only on the shared region
  always @(posedge i_ref_clk) begin
    if (i_wr_en && dec_common_hit) begin
      common_mem[dec_common_idx] <= i_wr_data; // RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Region of the current access

  localparam [1:0] RGN_UNIMPL = 2'h0;
  localparam [1:0] RGN_STATUS = 2'h1;
  localparam [1:0] RGN_CORE   = 2'h2;
  localparam [1:0] RGN_COMMON = 2'h3;

  reg        [1:0] access_rgn;

  // Status first, since it also sits in the core window
  always @* begin
    access_rgn = RGN_UNIMPL; // RULE14
    if (status_hit) begin
      access_rgn = RGN_STATUS;
    end else if (dec_core_hit) begin
      access_rgn = RGN_CORE; // RULE13
    end else if (dec_common_hit) begin
      access_rgn = RGN_COMMON; // RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux

  // Unimplemented and out of range locations read zero
  always @* begin
    nxt_rd_data = 8'h00;
    case (access_rgn)
      RGN_STATUS: begin
        nxt_rd_data = status_ff & `CSFB_STATUS_RD_MASK; // RULE4
      end
      RGN_CORE: begin
        nxt_rd_data = i_core_rd_data; // RULE13
      end
      RGN_COMMON: begin
        nxt_rd_data = common_mem[dec_common_idx]; // RULE15
      end
      default: begin
        nxt_rd_data = 8'h00; // RULE14
      end
    endcase
  end

  // Registered read answer
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= i_rd_en;
      if (i_rd_en) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding of other core register writes

  // Status writes are handled here, the rest go back to the core
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      core_wr_stb_ff  <= 1'b0;
      core_wr_idx_ff  <= 4'h0;
      core_wr_data_ff <= 8'h00;
    end else begin
      core_wr_stb_ff <= i_wr_en && dec_core_hit && !status_hit; // RULE13
      if (i_wr_en && dec_core_hit) begin
        core_wr_idx_ff  <= dec_core_idx;
        core_wr_data_ff <= i_wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ALU result reporting

  // Result of the last valid operation, valid as a pulse
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      alu_result_ff <= 8'h00;
      alu_valid_ff  <= 1'b0;
    end else begin
      alu_valid_ff <= i_op_valid;
      if (i_op_valid) begin
        alu_result_ff <= alu_result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address reporting

  // Address of the last access, held between accesses
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      data_addr_ff <= 12'h000;
      unmapped_ff  <= 1'b0;
    end else begin
      if (i_rd_en || i_wr_en) begin
        data_addr_ff <= dec_data_addr; // RULE16
      end
      // Accesses that touch nothing real
      unmapped_ff <= (i_rd_en || i_wr_en) && (dec_unimpl_hit || !dec_in_range); // RULE14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Every output straight from its flip-flop
  assign o_status          = status_ff;
  assign o_alu_result      = alu_result_ff;
  assign o_alu_valid       = alu_valid_ff;
  assign o_rd_data         = rd_data_ff;
  assign o_rd_valid        = rd_valid_ff;
  assign o_data_addr       = data_addr_ff;
  assign o_core_wr_stb     = core_wr_stb_ff;
  assign o_core_wr_idx     = core_wr_idx_ff;
  assign o_core_wr_data    = core_wr_data_ff;
  assign o_unmapped_access = unmapped_ff;

endmodule // csfb_core_status

// ---- test/csfb_core_status_chk.sv ----
`timescale 1ns/1ps
`include "csfb_map.vh"
// Port checker for the flags and bank map
module csfb_core_status_chk (
  input wire        i_ref_clk,
  input wire        i_rst,
  input wire [4:0]  i_bank_sel,
  input wire [6:0]  i_offset,
  input wire        i_rd_en,
  input wire        i_wr_en,
  input wire        i_op_valid,
  input wire [2:0]  i_op_kind,
  input wire        i_watchdog_clear_instr,
  input wire        i_sleep_instr,
  input wire        i_watchdog_timeout,
  input wire [7:0]  o_status,
  input wire [7:0]  o_alu_result,
  input wire [11:0] o_data_addr,
  input wire        o_unmapped_access
);
  wire any_evt;
  wire acc;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  // Event and access qualifiers
  assign any_evt = i_watchdog_clear_instr | i_sleep_instr | i_watchdog_timeout;
  assign acc     = i_rd_en | i_wr_en;
  ////////////////////////////////
  // Flag behaviour
  AST_UPPER: assert property (o_status[7:5] == 3'h0)
    else $error("upper flag bits not zero");
  AST_HOLD: assert property (!any_evt |=> $stable(o_status[4:3]))
    else $error("reset cause flags moved without event");
  AST_TMO: assert property (i_watchdog_timeout |=> !o_status[4])
    else $error("timeout did not clear watchdog flag");
  AST_SLP: assert property (i_sleep_instr |=> !o_status[3])
    else $error("sleep did not clear sleep flag");
  AST_ZERO: assert property (i_op_valid && i_op_kind == `CSFB_OP_ADD |=>
    o_status[2] == (o_alu_result == 8'h00)) else $error("zero flag wrong");
  AST_FCLR: assert property (i_op_valid && i_op_kind == `CSFB_OP_CLEAR |=>
    o_status[2] && o_alu_result == 8'h00) else $error("file clear wrong");
  ////////////////////////////////
  // Address map
  AST_UNMAP: assert property (acc && i_offset >= 7'h0c && i_offset < 7'h70 |=>
    o_unmapped_access) else $error("unmapped access not flagged");
  AST_ADDR: assert property (acc |=>
    o_data_addr == {$past(i_bank_sel), $past(i_offset)}) else $error("data address wrong");
endmodule // csfb_core_status_chk

bind csfb_core_status csfb_core_status_chk u_chk (.i_ref_clk, .i_rst, .i_bank_sel, .i_offset,
  .i_rd_en, .i_wr_en, .i_op_valid, .i_op_kind, .i_watchdog_clear_instr, .i_sleep_instr,
  .i_watchdog_timeout, .o_status, .o_alu_result, .o_data_addr, .o_unmapped_access);

// ---- test/csfb_core_model.sv ----
`timescale 1ns/1ps
// Core register file behind the map
module csfb_core_model (
  input  wire       i_ref_clk,
  input  wire       i_wr_stb,
  input  wire [3:0] i_wr_idx,
  input  wire [7:0] i_wr_data,
  input  wire [3:0] i_rd_idx,
  output wire [7:0] o_rd_data
);
  reg [7:0] regs_ff [0:15];
  integer   k;
  // Distinct start value per index
  initial begin
    for (k = 0; k < 16; k = k + 1) begin
      regs_ff[k] = 8'h5a ^ k[7:0];
    end
  end
  // Store forwarded core writes
  always @(posedge i_ref_clk) begin
    if (i_wr_stb) begin
      regs_ff[i_wr_idx] <= i_wr_data;
    end
  end
  // Same cycle read answer
  assign o_rd_data = regs_ff[i_rd_idx];
endmodule // csfb_core_model

// ---- test/core_status_flags_bank_map_tb.sv ----
`timescale 1ns/1ps
`include "csfb_map.vh"
module core_status_flags_bank_map_tb;
  reg         i_ref_clk, i_rst, i_rd_en, i_wr_en, i_op_valid;
  reg         i_watchdog_clear_instr, i_sleep_instr, i_watchdog_timeout;
  reg  [4:0]  i_bank_sel, st;
  reg  [6:0]  i_offset;
  reg  [7:0]  i_wr_data, i_op_a, i_op_b;
  reg  [2:0]  i_op_kind;
  wire [7:0]  i_core_rd_data, o_status, o_alu_result, o_rd_data, o_core_wr_data;
  wire [11:0] o_data_addr;
  wire [3:0]  o_core_wr_idx;
  wire        o_alu_valid, o_rd_valid, o_core_wr_stb, o_unmapped_access;
  integer     seed, err_total, comparisons, cycles, n;
  reg  [12:0] e;
  reg  [31:0] r1, r2;
  ////////////////////////////////
  csfb_core_status uut (.i_ref_clk, .i_rst, .i_bank_sel, .i_offset, .i_rd_en, .i_wr_en,
    .i_wr_data, .i_core_rd_data, .i_op_valid, .i_op_kind, .i_op_a, .i_op_b,
    .i_watchdog_clear_instr, .i_sleep_instr, .i_watchdog_timeout, .o_status, .o_alu_result,
    .o_alu_valid, .o_rd_data, .o_rd_valid, .o_data_addr, .o_core_wr_stb, .o_core_wr_idx,
    .o_core_wr_data, .o_unmapped_access);
  csfb_core_model u_core (.i_ref_clk(i_ref_clk), .i_wr_stb(o_core_wr_stb),
    .i_wr_idx(o_core_wr_idx), .i_wr_data(o_core_wr_data), .i_rd_idx(i_offset[3:0]),
    .o_rd_data(i_core_rd_data));
  // Clock and hang guard
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  ////////////////////////////////
  // Expected result and flags
  function [12:0] alu(input [2:0] k, input [7:0] a, input [7:0] b, input [4:0] s);
    reg [8:0] t;
    reg [4:0] h;
    reg [4:0] f;
    begin
      f = s;
      t = {1'b0, a};
      h = 5'h0;
      if (k == `CSFB_OP_ADD) begin
        t = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      end
      if (k == `CSFB_OP_SUB) begin
        t = {1'b0, a} + {1'b0, ~b} + 9'h1;
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h1;
      end
      if (k == `CSFB_OP_ROT_RIGHT) t = {a[0], s[0], a[7:1]};
      if (k == `CSFB_OP_ROT_LEFT) t = {a[7], a[6:0], s[0]};
      if (k == `CSFB_OP_CLEAR) t = 9'h0;
      if (k == `CSFB_OP_ADD || k == `CSFB_OP_SUB) f[1:0] = {h[4], t[8]};
      if (k == `CSFB_OP_ROT_RIGHT || k == `CSFB_OP_ROT_LEFT) f[0] = t[8];
      else if (k != `CSFB_OP_NONE) f[2] = (t[7:0] == 8'h0);
      alu = {t[7:0], f};
    end
  endfunction
  // Compare and count
  task chk(input [11:0] got, input [11:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One cycle of stimulus, events tracked in the model
  task go(input [4:0] b, input [6:0] o, input r, input w, input [7:0] d, input ov,
          input [2:0] k, input [7:0] a, input [7:0] bb, input [2:0] ev);
    begin
      {i_bank_sel, i_offset, i_rd_en, i_wr_en, i_wr_data} = {b, o, r, w, d};
      {i_op_valid, i_op_kind, i_op_a, i_op_b} = {ov, k, a, bb};
      {i_watchdog_timeout, i_sleep_instr, i_watchdog_clear_instr} = ev;
      if (ev[0]) st[4:3] = 2'b11;
      if (ev[1]) st[4:3] = 2'b10;
      if (ev[2]) st[4] = 1'b0;
      @(posedge i_ref_clk);
      #1;
    end
  endtask
  // Operation, optionally also writing the flags register
  task op(input w, input [7:0] d, input [2:0] k, input [7:0] a, input [7:0] b, input [2:0] ev);
    begin
      e = alu(k, a, b, st);
      go(5'h0c, 7'h03, 1'b0, w, d, 1'b1, k, a, b, ev);
      st[2:0] = (k == `CSFB_OP_NONE && w) ? d[2:0] : e[2:0];
      chk(o_status, {3'h0, st});
      chk(o_alu_result, e[12:5]);
      chk(o_alu_valid, 1'b1);
    end
  endtask
  // Plain register access
  task acc(input [4:0] b, input [6:0] o, input r, input w, input [7:0] d);
    begin
      go(b, o, r, w, d, 1'b0, 3'h0, 8'h0, 8'h0, 3'h0);
      chk(o_data_addr, {b, o});
    end
  endtask
  task complete_run;
    begin
      $display("errors=%0d comparisons=%0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  ////////////////////////////////
  // Main sequence
  initial begin
    {seed, err_total, comparisons, cycles} = {32'ha371, 96'h0};
    {i_ref_clk, i_rst, st} = {2'b01, 5'h18};
    {i_bank_sel, i_offset, i_rd_en, i_wr_en, i_wr_data, i_op_valid, i_op_kind} = 0;
    {i_op_a, i_op_b, i_watchdog_clear_instr, i_sleep_instr, i_watchdog_timeout} = 0;
    repeat (5) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    chk(o_status, 8'h18);
    acc(5'h08, 7'h03, 1'b0, 1'b1, 8'hff);
    chk(o_core_wr_stb, 1'b0);
    st[2:0] = 3'h7;
    chk(o_status, {3'h0, st});
    op(1'b1, 8'hff, 3'h1, 8'h0f, 8'h01, 3'h0);
    op(1'b1, 8'h00, 3'h6, 8'h00, 8'h00, 3'h0);
    for (n = 1; n < 8; n = n + 1) begin
      go(5'h08, 7'h40, 1'b0, 1'b0, 8'h0, 1'b0, 3'h0, 8'h0, 8'h0, n[2:0]);
      chk(o_status, {3'h0, st});
    end
    op(1'b0, 8'h00, 3'h2, 8'h05, 8'h05, 3'h0);
    op(1'b0, 8'h00, 3'h2, 8'h00, 8'h01, 3'h0);
    op(1'b0, 8'h00, 3'h1, 8'hff, 8'h01, 3'h0);
    op(1'b0, 8'h00, 3'h5, 8'h80, 8'h00, 3'h0);
    op(1'b0, 8'h00, 3'h4, 8'h01, 8'h00, 3'h0);
    op(1'b0, 8'h00, 3'h3, 8'h00, 8'h00, 3'h0);
    for (n = 0; n < 80; n = n + 1) begin
      r1 = $random(seed);
      r2 = $random(seed);
      op(r1[0], r1[15:8], r1[18:16] % 3'h7, r2[7:0], r2[15:8],
         r1[27] ? r1[26:24] : 3'h0);
    end
    acc(5'h17, 7'h03, 1'b1, 1'b0, 8'h0);
    chk(o_rd_data, {3'h0, st});
    chk(o_rd_valid, 1'b1);
    acc(5'h11, 7'h05, 1'b0, 1'b1, r1[7:0]);
    chk({o_core_wr_stb, o_core_wr_idx}, 5'h15);
    // Forwarded write reaches the core one cycle later
    acc(5'h16, 7'h05, 1'b1, 1'b0, 8'h0);
    acc(5'h16, 7'h05, 1'b1, 1'b0, 8'h0);
    chk(o_rd_data, r1[7:0]);
    acc(5'h08, 7'h20, 1'b0, 1'b1, 8'hff);
    chk(o_unmapped_access, 1'b1);
    acc(5'h08, 7'h20, 1'b1, 1'b0, 8'h0);
    chk(o_rd_data, 8'h00);
    acc(5'h07, 7'h70, 1'b1, 1'b0, 8'h0);
    chk({o_unmapped_access, o_rd_data}, 9'h100);
    acc(5'h09, 7'h75, 1'b0, 1'b1, r2[23:16]);
    acc(5'h16, 7'h75, 1'b1, 1'b0, 8'h0);
    chk(o_rd_data, r2[23:16]);
    i_rst = 1'b1;
    @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    chk(o_status, 8'h18);
    complete_run;
  end
endmodule // core_status_flags_bank_map_tb
